// *** shared/agt_defs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef AGT_DEFS_SVH
`define AGT_DEFS_SVH
`define AGT_OFF_CTRL     8'h00
`define AGT_OFF_MODE     8'h04
`define AGT_OFF_STS      8'h10
`define AGT_OFF_IMR      8'h14
`define AGT_OFF_KEY      8'h20
`define AGT_OFF_INPUT_BLOCK_WORD    8'h40
`define AGT_OFF_ODATA    8'h50
`define AGT_OFF_IV       8'h60
`define AGT_OFF_AUTH_DATA_LENGTH   8'h70
`define AGT_OFF_CIPHER_TEXT_LENGTH     8'h74
`define AGT_OFF_CTR      8'h78
`define AGT_OFF_GHASH    8'h80
`define AGT_OFF_HKEY     8'h90
`define AGT_CTRL_START   0
`define AGT_MODE_ENC     0
`define AGT_MODE_TAG     1
`define AGT_MODE_START_MODE_SELECT    8
`define AGT_MODE_OPERATION_MODE_SELECT   12
`define AGT_OPERATION_MODE_SELECT_GCM    3'h5
`define AGT_START_MODE_SELECT_MANUAL  2'h0
`define AGT_START_MODE_SELECT_AUTO    2'h1
`define AGT_STS_RDY      0
`define AGT_MODE_RST     32'h0000_0000
`define AGT_BLK_BYTES    32'h0000_0010
`define AGT_KEYGEN_LAST  7'h03
`define AGT_MUL_LAST     7'h7f
`define AGT_GF_R         128'he100_0000_0000_0000_0000_0000_0000_0000
`define AGT_RESP_OKAY    2'h0
`define AGT_RESP_SLVERR  2'h2
`endif

// *** shared/agt_pkg.sv ***
// Types shared by the fragment and tag engine
package agt_pkg;
    typedef enum logic [1:0] {
        AGT_IDLE   = 2'b00,
        AGT_KEYGEN = 2'b01,
        AGT_MUL    = 2'b10
    } agt_state_t;
endpackage

// *** core/agt_gcm_core.sv ***
// Galois/Counter fragment engine with hash register and AXI4-Lite slave
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "agt_defs.svh"
module agt_gcm_core (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output logic              irq
);
    logic                 awready_r, awready_nxt, aw_have_r, aw_have_nxt;
    logic                 wready_r, wready_nxt, w_have_r, w_have_nxt;
    logic [7:0]           aw_addr_r, aw_addr_nxt;
    logic [31:0]          w_data_r, w_data_nxt;
    logic [3:0]           w_strb_r, w_strb_nxt;
    logic                 bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic                 rvalid_r, rvalid_nxt, irq_r, irq_nxt;
    logic [1:0]           bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]          rdata_r, rdata_nxt;
    logic [31:0]          mode_r, mode_nxt, auth_data_length_r, auth_data_length_nxt, cipher_text_length_r, cipher_text_length_nxt;
    logic [31:0]          aad_cnt_r, aad_cnt_nxt, c_cnt_r, c_cnt_nxt, mask_r, mask_nxt;
    logic                 rdy_r, rdy_nxt, len_ph_r, len_ph_nxt;
    logic [127:0]         key_r, key_nxt, in_r, in_nxt, out_r, out_nxt, iv_r, iv_nxt;
    logic [127:0]         hash_r, hash_nxt, hk_r, hk_nxt, z_r, z_nxt, v_r, v_nxt, y_r, y_nxt;
    logic [3:0]           in_mask_r, in_mask_nxt;
    logic [6:0]           cnt_r, cnt_nxt;
    agt_pkg::agt_state_t  state_r, state_nxt;
    logic                 wr_go, idle, is_aad, start, rd_ok, wr_ok;
    logic [1:0]           wi, ri;
    logic [31:0]          ctr_inc, rd_val;
    logic [127:0]         ks, ob, cblk, z_fin, v_sh, lenblk;

    function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic grp(input logic [7:0] a, input logic [7:0] off);
        return {a[7:4], 4'h0} == off;
    endfunction

    function automatic logic sng(input logic [7:0] a, input logic [7:0] off);
        return {a[7:2], 2'b00} == off;
    endfunction

    assign wr_go   = aw_have_r && w_have_r && !bvalid_r;
    assign idle    = state_r == agt_pkg::AGT_IDLE;
    assign wi      = aw_addr_r[3:2];
    assign ri      = s_axi_araddr[3:2];
    assign is_aad  = aad_cnt_r < auth_data_length_r;
    assign ctr_inc = iv_r[31:0] + 32'h1;
    // Keystream stand-in for the block cipher core: key mixed with counter block
    assign ks      = key_r ^ {iv_r[127:32], ctr_inc};
    // Bit-serial GF(2^128) multiply step
    assign z_fin   = y_r[127] ? (z_r ^ v_r) : z_r;
    assign v_sh    = v_r[0] ? ({1'b0, v_r[127:1]} ^ `AGT_GF_R) : {1'b0, v_r[127:1]};
    assign lenblk  = {29'h0, auth_data_length_r, 3'h0, 29'h0, cipher_text_length_r, 3'h0};
    assign wr_ok   = sng(aw_addr_r, `AGT_OFF_CTRL) || sng(aw_addr_r, `AGT_OFF_MODE)
                  || sng(aw_addr_r, `AGT_OFF_STS) || sng(aw_addr_r, `AGT_OFF_IMR)
                  || grp(aw_addr_r, `AGT_OFF_KEY) || grp(aw_addr_r, `AGT_OFF_INPUT_BLOCK_WORD)
                  || grp(aw_addr_r, `AGT_OFF_IV) || sng(aw_addr_r, `AGT_OFF_AUTH_DATA_LENGTH)
                  || sng(aw_addr_r, `AGT_OFF_CIPHER_TEXT_LENGTH) || grp(aw_addr_r, `AGT_OFF_GHASH)
                  || grp(aw_addr_r, `AGT_OFF_HKEY);

    // Read decode
    always_comb begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        if (sng(s_axi_araddr, `AGT_OFF_MODE)) begin
            rd_val = mode_r;
        end else if (sng(s_axi_araddr, `AGT_OFF_STS)) begin
            rd_val = {31'h0, rdy_r};
        end else if (sng(s_axi_araddr, `AGT_OFF_IMR)) begin
            rd_val = mask_r;
        end else if (grp(s_axi_araddr, `AGT_OFF_ODATA)) begin
            rd_val = out_r[(3 - ri) * 32 +: 32];
        end else if (grp(s_axi_araddr, `AGT_OFF_IV)) begin
            rd_val = iv_r[(3 - ri) * 32 +: 32];
        end else if (sng(s_axi_araddr, `AGT_OFF_AUTH_DATA_LENGTH)) begin
            rd_val = auth_data_length_r;
        end else if (sng(s_axi_araddr, `AGT_OFF_CIPHER_TEXT_LENGTH)) begin
            rd_val = cipher_text_length_r;
        end else if (sng(s_axi_araddr, `AGT_OFF_CTR)) begin
            rd_val = iv_r[31:0];
        end else if (grp(s_axi_araddr, `AGT_OFF_GHASH)) begin
            rd_val = hash_r[(3 - ri) * 32 +: 32];
        end else if (grp(s_axi_araddr, `AGT_OFF_HKEY)) begin
            rd_val = hk_r[(3 - ri) * 32 +: 32];
        end else if (!(sng(s_axi_araddr, `AGT_OFF_CTRL) || grp(s_axi_araddr, `AGT_OFF_KEY)
                     || grp(s_axi_araddr, `AGT_OFF_INPUT_BLOCK_WORD))) begin
            rd_ok = 1'b0;
        end
    end

    // Next state of bus slave, registers and hash engine
    always_comb begin
        awready_nxt = awready_r;  aw_have_nxt = aw_have_r;  aw_addr_nxt = aw_addr_r;
        wready_nxt  = wready_r;   w_have_nxt  = w_have_r;   w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;   bvalid_nxt  = bvalid_r;   bresp_nxt   = bresp_r;
        arready_nxt = arready_r;  rvalid_nxt  = rvalid_r;   rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;    mode_nxt    = mode_r;     auth_data_length_nxt  = auth_data_length_r;
        cipher_text_length_nxt    = cipher_text_length_r;     aad_cnt_nxt = aad_cnt_r;  c_cnt_nxt   = c_cnt_r;
        mask_nxt    = mask_r;     rdy_nxt     = rdy_r;      len_ph_nxt  = len_ph_r;
        key_nxt     = key_r;      in_nxt      = in_r;       out_nxt     = out_r;
        iv_nxt      = iv_r;       hash_nxt    = hash_r;     hk_nxt      = hk_r;
        z_nxt       = z_r;        v_nxt       = v_r;        y_nxt       = y_r;
        in_mask_nxt = in_mask_r;  cnt_nxt     = cnt_r;      state_nxt   = state_r;
        start       = 1'b0;
        if (s_axi_awvalid && awready_r) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
            awready_nxt = 1'b0;
        end
        if (s_axi_wvalid && wready_r) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
            wready_nxt = 1'b0;
        end
        if (wr_go) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_ok ? `AGT_RESP_OKAY : `AGT_RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt  = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt  = 1'b1;
        end
        if (s_axi_arvalid && arready_r) begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rdata_nxt   = rd_val;
            rresp_nxt   = rd_ok ? `AGT_RESP_OKAY : `AGT_RESP_SLVERR;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
        if (wr_go && sng(aw_addr_r, `AGT_OFF_STS) && w_strb_r[0]) begin
            rdy_nxt = rdy_r & ~w_data_r[`AGT_STS_RDY];
        end
        if (wr_go && sng(aw_addr_r, `AGT_OFF_IMR)) begin
            mask_nxt = mrg(mask_r, w_data_r, w_strb_r);
        end
        // Mode, key, data, IV, length, hash and subkey words are taken only while the engine is idle
        if (wr_go && idle) begin
            if (sng(aw_addr_r, `AGT_OFF_MODE)) begin
                mode_nxt = mrg(mode_r, w_data_r, w_strb_r);
            end
            if (grp(aw_addr_r, `AGT_OFF_KEY)) begin
                key_nxt[(3 - wi) * 32 +: 32] = mrg(key_r[(3 - wi) * 32 +: 32], w_data_r, w_strb_r);
                if (wi == 2'h3 && mode_r[`AGT_MODE_OPERATION_MODE_SELECT +: 3] == `AGT_OPERATION_MODE_SELECT_GCM) begin
                    state_nxt = agt_pkg::AGT_KEYGEN;
                    cnt_nxt   = 7'h0;
                end
            end
            if (grp(aw_addr_r, `AGT_OFF_INPUT_BLOCK_WORD)) begin
                in_nxt[(3 - wi) * 32 +: 32] = mrg(in_r[(3 - wi) * 32 +: 32], w_data_r, w_strb_r);
                in_mask_nxt[wi] = 1'b1;
                if (mode_r[`AGT_MODE_START_MODE_SELECT +: 2] == `AGT_START_MODE_SELECT_AUTO && (&in_mask_nxt)) begin
                    start = 1'b1;
                end
            end
            if (sng(aw_addr_r, `AGT_OFF_CTRL) && w_data_r[`AGT_CTRL_START] && (&in_mask_r)
                && mode_r[`AGT_MODE_START_MODE_SELECT +: 2] == `AGT_START_MODE_SELECT_MANUAL) begin
                start = 1'b1;
            end
            if (grp(aw_addr_r, `AGT_OFF_IV)) begin
                iv_nxt[(3 - wi) * 32 +: 32] = mrg(iv_r[(3 - wi) * 32 +: 32], w_data_r, w_strb_r);
            end
            if (sng(aw_addr_r, `AGT_OFF_AUTH_DATA_LENGTH) || sng(aw_addr_r, `AGT_OFF_CIPHER_TEXT_LENGTH)) begin
                aad_cnt_nxt = 32'h0;
                c_cnt_nxt   = 32'h0;
            end
            if (sng(aw_addr_r, `AGT_OFF_AUTH_DATA_LENGTH)) begin
                auth_data_length_nxt = mrg(auth_data_length_r, w_data_r, w_strb_r);
            end
            if (sng(aw_addr_r, `AGT_OFF_CIPHER_TEXT_LENGTH)) begin
                cipher_text_length_nxt = mrg(cipher_text_length_r, w_data_r, w_strb_r);
            end
            if (grp(aw_addr_r, `AGT_OFF_GHASH)) begin
                hash_nxt[(3 - wi) * 32 +: 32] = mrg(hash_r[(3 - wi) * 32 +: 32], w_data_r, w_strb_r);
            end
            if (grp(aw_addr_r, `AGT_OFF_HKEY)) begin
                hk_nxt[(3 - wi) * 32 +: 32] = mrg(hk_r[(3 - wi) * 32 +: 32], w_data_r, w_strb_r);
            end
        end
        ob          = in_nxt ^ ks;
        cblk        = mode_r[`AGT_MODE_ENC] ? ob : in_nxt;
        unique case (state_r)
            agt_pkg::AGT_IDLE: begin
                if (start) begin
                    in_mask_nxt = 4'h0;
                    z_nxt       = 128'h0;
                    y_nxt       = hk_r;
                    cnt_nxt     = 7'h0;
                    len_ph_nxt  = 1'b0;
                    state_nxt   = agt_pkg::AGT_MUL;
                    if (is_aad) begin
                        v_nxt       = hash_r ^ in_nxt;
                        aad_cnt_nxt = aad_cnt_r + `AGT_BLK_BYTES;
                    end else begin
                        v_nxt       = hash_r ^ cblk;
                        out_nxt     = ob;
                        iv_nxt      = {iv_r[127:32], ctr_inc};
                        c_cnt_nxt   = c_cnt_r + `AGT_BLK_BYTES;
                    end
                end
            end
            agt_pkg::AGT_KEYGEN: begin
                cnt_nxt = cnt_r + 7'h1;
                if (cnt_r == `AGT_KEYGEN_LAST) begin
                    hk_nxt    = key_r;
                    rdy_nxt   = 1'b1;
                    state_nxt = agt_pkg::AGT_IDLE;
                end
            end
            agt_pkg::AGT_MUL: begin
                z_nxt   = z_fin;
                v_nxt   = v_sh;
                y_nxt   = {y_r[126:0], 1'b0};
                cnt_nxt = cnt_r + 7'h1;
                if (cnt_r == `AGT_MUL_LAST) begin
                    hash_nxt = z_fin;
                    if (mode_r[`AGT_MODE_TAG] && !len_ph_r && !is_aad && c_cnt_r >= cipher_text_length_r) begin
                        z_nxt      = 128'h0;
                        v_nxt      = z_fin ^ lenblk;
                        y_nxt      = hk_r;
                        cnt_nxt    = 7'h0;
                        len_ph_nxt = 1'b1;
                    end else begin
                        rdy_nxt    = 1'b1;
                        len_ph_nxt = 1'b0;
                        state_nxt  = agt_pkg::AGT_IDLE;
                    end
                end
            end
        endcase
        irq_nxt = rdy_nxt & mask_nxt[`AGT_STS_RDY];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;   aw_have_r <= 1'b0;   aw_addr_r <= 8'h0;
            wready_r  <= 1'b1;   w_have_r  <= 1'b0;   w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;   bvalid_r  <= 1'b0;   bresp_r   <= 2'h0;
            arready_r <= 1'b1;   rvalid_r  <= 1'b0;   rdata_r   <= 32'h0;
            rresp_r   <= 2'h0;   irq_r     <= 1'b0;   mode_r    <= `AGT_MODE_RST;
            auth_data_length_r  <= 32'h0;  cipher_text_length_r    <= 32'h0;  aad_cnt_r <= 32'h0;
            c_cnt_r   <= 32'h0;  mask_r    <= 32'h0;  rdy_r     <= 1'b0;
            len_ph_r  <= 1'b0;   key_r     <= 128'h0; in_r      <= 128'h0;
            out_r     <= 128'h0; iv_r      <= 128'h0; hash_r    <= 128'h0;
            hk_r      <= 128'h0; z_r       <= 128'h0; v_r       <= 128'h0;
            y_r       <= 128'h0; in_mask_r <= 4'h0;   cnt_r     <= 7'h0;
            state_r   <= agt_pkg::AGT_IDLE;
        end else begin
            awready_r <= awready_nxt; aw_have_r <= aw_have_nxt; aw_addr_r <= aw_addr_nxt;
            wready_r  <= wready_nxt;  w_have_r  <= w_have_nxt;  w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;  bvalid_r  <= bvalid_nxt;  bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt; rvalid_r  <= rvalid_nxt;  rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;   irq_r     <= irq_nxt;     mode_r    <= mode_nxt;
            auth_data_length_r  <= auth_data_length_nxt;  cipher_text_length_r    <= cipher_text_length_nxt;    aad_cnt_r <= aad_cnt_nxt;
            c_cnt_r   <= c_cnt_nxt;   mask_r    <= mask_nxt;    rdy_r     <= rdy_nxt;
            len_ph_r  <= len_ph_nxt;  key_r     <= key_nxt;     in_r      <= in_nxt;
            out_r     <= out_nxt;     iv_r      <= iv_nxt;      hash_r    <= hash_nxt;
            hk_r      <= hk_nxt;      z_r       <= z_nxt;       v_r       <= v_nxt;
            y_r       <= y_nxt;       in_mask_r <= in_mask_nxt; cnt_r     <= cnt_nxt;
            state_r   <= state_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign irq           = irq_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence mul_launch_s;
        idle && start;
    endsequence
    sequence mul_run_s;
        (cnt_r == 7'h0 && state_r == agt_pkg::AGT_MUL) ##127
        (cnt_r == 7'h7f && state_r == agt_pkg::AGT_MUL);
    endsequence

    subkey_load_a: assert property (
        (state_r == agt_pkg::AGT_KEYGEN && cnt_r == 7'h3)
        |=> (hk_r == $past(key_r) && rdy_r && idle))
        else $error("subkey not loaded at end of derivation");
    len_restart_a: assert property (
        (wr_go && idle && sng(aw_addr_r, `AGT_OFF_CIPHER_TEXT_LENGTH))
        |=> (aad_cnt_r == 32'h0 && c_cnt_r == 32'h0))
        else $error("length write did not restart fragment counts");
    aad_no_out_a: assert property (
        (mul_launch_s and is_aad) |=> $stable(out_r))
        else $error("output changed on authenticated data block");
    ready_set_a: assert property (
        (state_r == agt_pkg::AGT_MUL && cnt_r == 7'h7f && !mode_r[1]) |=> (rdy_r && idle))
        else $error("ready flag not set after block");
    hash_hold_a: assert property (
        (idle && !wr_go) |=> $stable(hash_r))
        else $error("hash changed while idle");
    mul_span_a: assert property (
        mul_launch_s |=> mul_run_s ##1 (hash_r == $past(z_fin)))
        else $error("hash multiply did not take 128 cycles");
    irq_mask_a: assert property (
        (rdy_r && mask_r[0]) |-> irq)
        else $error("unmasked ready without interrupt");
endmodule

// *** tb/agt_host_model.sv ***
// Register bus host model: AXI4-Lite master driven by the bench scenarios
`timescale 1ns/1ns
module agt_host_model (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // Response ready lines are held high so every answer is taken at once
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid} = '0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the fragment and tag engine
`timescale 1ns/1ns
`include "agt_defs.svh"
module testbench;
    logic aclk, aresetn, irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv, ctr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [127:0] v, hs, ob;
    int err_count;
    int cmp_count;
    localparam logic [127:0] KEY = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
    localparam logic [127:0] HK  = 128'h6a09_e667_bb67_ae85_3c6e_f372_a54f_f53a;
    localparam logic [127:0] J0  = 128'h1111_2222_3333_4444_5555_6666_7777_8881;
    localparam logic [127:0] BA  = 128'hfeed_0001_0203_0405_0607_0809_0a0b_0c0d;
    localparam logic [127:0] BC  = 128'h0123_4567_89ab_cdef_1032_5476_98ba_dcfe;

    agt_gcm_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    agt_host_model u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input logic [127:0] g, input logic [127:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [127:0] gmul(input logic [127:0] x, input logic [127:0] y);
        logic [127:0] z;
        logic [127:0] t;
        z = '0;
        t = y;
        for (int i = 127; i >= 0; i--) begin
            if (x[i]) z ^= t;
            t = t[0] ? ((t >> 1) ^ `AGT_GF_R) : (t >> 1);
        end
        return z;
    endfunction

    function automatic logic [31:0] mode(input logic [1:0] sm);
        return (32'(`AGT_OPERATION_MODE_SELECT_GCM) << `AGT_MODE_OPERATION_MODE_SELECT) | (32'(sm) << `AGT_MODE_START_MODE_SELECT) | 32'h1;
    endfunction

    task automatic w4(input logic [7:0] a, input logic [127:0] d);
        for (int i = 0; i < 4; i++)
            u_host.wr(a + 8'(4 * i), d[127 - 32 * i -: 32], rs);
    endtask

    task automatic r4(input logic [7:0] a, output logic [127:0] d);
        for (int i = 0; i < 4; i++) begin
            u_host.rd(a + 8'(4 * i), rv, rs);
            d[127 - 32 * i -: 32] = rv;
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        rv = '0;
        while (rv[`AGT_STS_RDY] !== 1'b1 && n < 400) begin
            u_host.rd(`AGT_OFF_STS, rv, rs);
            n++;
        end
        chk(rv[`AGT_STS_RDY], 1'b1);
    endtask

    task automatic t_regs();
        u_host.rd(`AGT_OFF_MODE, rv, rs);
        chk(rv, `AGT_MODE_RST);
        u_host.rd(8'hfc, rv, rs);
        chk(rs, `AGT_RESP_SLVERR);
        u_host.wr(`AGT_OFF_CTR, 32'h1, rs);
        chk(rs, `AGT_RESP_SLVERR);
    endtask

    task automatic t_key();
        u_host.wr(`AGT_OFF_MODE, mode(`AGT_START_MODE_SELECT_AUTO), rs);
        w4(`AGT_OFF_KEY, KEY);
        wait_rdy();
        chk(irq, 1'b0);
        u_host.wr(`AGT_OFF_IMR, 32'h1, rs);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b1);
        u_host.wr(`AGT_OFF_STS, 32'h1, rs);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        r4(`AGT_OFF_HKEY, v);
        chk(v, KEY);
        w4(`AGT_OFF_HKEY, HK);
        r4(`AGT_OFF_HKEY, v);
        chk(v, HK);
    endtask

    task automatic t_frag_aad();
        w4(`AGT_OFF_IV, J0);
        u_host.wr(`AGT_OFF_AUTH_DATA_LENGTH, `AGT_BLK_BYTES, rs);
        u_host.wr(`AGT_OFF_CIPHER_TEXT_LENGTH, `AGT_BLK_BYTES, rs);
        w4(`AGT_OFF_GHASH, 128'h0);
        w4(`AGT_OFF_INPUT_BLOCK_WORD, BA);
        wait_rdy();
        hs = gmul(BA, HK);
        r4(`AGT_OFF_GHASH, v);
        chk(v, hs);
        r4(`AGT_OFF_ODATA, v);
        chk(v, 128'h0);
        u_host.wr(`AGT_OFF_STS, 32'h1, rs);
    endtask

    task automatic t_frag_ct();
        u_host.wr(`AGT_OFF_MODE, mode(`AGT_START_MODE_SELECT_MANUAL), rs);
        w4(`AGT_OFF_IV, J0);
        u_host.wr(`AGT_OFF_AUTH_DATA_LENGTH, 32'h0, rs);
        u_host.wr(`AGT_OFF_CIPHER_TEXT_LENGTH, `AGT_BLK_BYTES, rs);
        w4(`AGT_OFF_GHASH, hs);
        w4(`AGT_OFF_INPUT_BLOCK_WORD, BC);
        u_host.wr(`AGT_OFF_CTRL, 32'h1, rs);
        wait_rdy();
        ctr = J0[31:0] + 32'h1;
        ob = BC ^ KEY ^ {J0[127:32], ctr};
        r4(`AGT_OFF_ODATA, v);
        chk(v, ob);
        r4(`AGT_OFF_GHASH, v);
        chk(v, gmul(hs ^ ob, HK));
        u_host.rd(`AGT_OFF_CTR, rv, rs);
        chk(rv, ctr);
    endtask

    task automatic t_tag();
        logic [127:0] fin;
        logic [127:0] lens;
        fin = gmul(hs ^ ob, HK);
        lens = 128'h0000_0000_0000_0080_0000_0000_0000_0080;
        // Manual tag: the length block is hashed as one authenticated data block
        wait_rdy();
        u_host.wr(`AGT_OFF_STS, 32'h1, rs);
        u_host.wr(`AGT_OFF_MODE, mode(`AGT_START_MODE_SELECT_AUTO), rs);
        u_host.wr(`AGT_OFF_AUTH_DATA_LENGTH, `AGT_BLK_BYTES, rs);
        u_host.wr(`AGT_OFF_CIPHER_TEXT_LENGTH, 32'h0, rs);
        w4(`AGT_OFF_INPUT_BLOCK_WORD, lens);
        wait_rdy();
        r4(`AGT_OFF_GHASH, v);
        chk(v, gmul(fin ^ lens, HK));
        // Automatic tag: the length block follows the last cipher block
        u_host.wr(`AGT_OFF_STS, 32'h1, rs);
        u_host.wr(`AGT_OFF_MODE, mode(`AGT_START_MODE_SELECT_MANUAL) | (32'h1 << `AGT_MODE_TAG), rs);
        w4(`AGT_OFF_IV, J0);
        u_host.wr(`AGT_OFF_AUTH_DATA_LENGTH, 32'h0, rs);
        u_host.wr(`AGT_OFF_CIPHER_TEXT_LENGTH, `AGT_BLK_BYTES, rs);
        w4(`AGT_OFF_GHASH, hs);
        w4(`AGT_OFF_INPUT_BLOCK_WORD, BC);
        u_host.wr(`AGT_OFF_CTRL, 32'h1, rs);
        wait_rdy();
        r4(`AGT_OFF_GHASH, v);
        chk(v, gmul(fin ^ {64'h0, 64'h80}, HK));
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        test_done();
    end

    initial begin
        aresetn = 1'b0;
        err_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_key();
        t_frag_aad();
        t_frag_ct();
        t_tag();
        test_done();
    end
endmodule
